// [mux_adc_cfg.svh]
/*
 * constants of the converter cycle controller: bus offsets, reset values, timebase counts.
 * assumes a 20 MHz system clock and byte addresses on a 32-bit AHB-Lite bus.
 */
`ifndef MUX_ADC_CFG_SVH
`define MUX_ADC_CFG_SVH

// ****************************************************************
// clock and timebase
// ****************************************************************
`define CFG_CLK_HZ 20000000
`define CFG_OSC_50HZ_HZ 128000
`define CFG_OSC_60HZ_HZ 153600
`define CFG_DIV_50HZ ((`CFG_CLK_HZ) / (`CFG_OSC_50HZ_HZ))
`define CFG_DIV_60HZ ((`CFG_CLK_HZ) / (`CFG_OSC_60HZ_HZ))
`define CFG_NULL_DIV 2560
`define CFG_CONV_TICKS 20510
`define CFG_EXT_TIMEOUT 16384

// ****************************************************************
// output word
// ****************************************************************
`define CFG_WORD_BITS 24
`define CFG_CODE_MAX_POS 22'h11ffff
`define CFG_CODE_MIN_NEG 22'h3e0000

// ****************************************************************
// register map and reset values
// ****************************************************************
`define CFG_OFF_CONV_LEN 8'h00
`define CFG_OFF_STATUS 8'h04
`define CFG_OFF_RESULT 8'h08
`define CFG_OFF_CHANNEL 8'h0c
`define CFG_RST_CONV_LEN 32'h0000501e

`endif

// [mux_adc_ctrl.sv]
/*
 * digital control of a multiplexed single-cycle-settling converter: cycle sequencer,
 * channel address path, 24-bit result shifter, conversion timebase and an AHB-Lite slave.
 * assumes all pin inputs are synchronous to i_mclk and the filter value is stable at
 * the end of each conversion.
 */
`timescale 1ns/1ns
`default_nettype none
`include "mux_adc_cfg.svh"

module mux_adc_ctrl #(
  parameter logic [63:0] CHAN_MAP = 64'hfedcba98_00000000,
  parameter int EXT_TIMEOUT = `CFG_EXT_TIMEOUT
) (
  input wire logic i_mclk,
  input wire logic i_reset_n,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic [31:0] o_hrdata,
  output logic o_hreadyout,
  output logic o_hresp,
  input wire logic i_converter_select_n,
  input wire logic i_channel_select_n,
  input wire logic i_addr_clk,
  input wire logic i_addr_in,
  input wire logic i_shift_clk,
  input wire logic i_rate_select_in,
  input wire logic [21:0] i_filter_value,
  output logic o_sdo,
  output logic o_sdo_oe,
  output logic [7:0] o_channel_switch,
  output logic o_channel_enable,
  output logic o_low_power
);

  // ****************************************************************
  // pin edge detection
  // ****************************************************************
  logic cs_prev_reg;
  logic chan_prev_reg;
  logic aclk_prev_reg;
  logic sclk_prev_reg;
  logic rate_prev_reg;
  logic cs_rise;
  logic chan_fall;
  logic aclk_rise;
  logic sclk_fall;
  logic rate_rise;
  logic rate_edge;

  // inputs are synchronous, so one stage of history is enough for edges
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cs_prev_reg <= 1'b1;
      chan_prev_reg <= 1'b1;
      aclk_prev_reg <= 1'b0;
      sclk_prev_reg <= 1'b0;
      rate_prev_reg <= 1'b0;
    end else begin
      cs_prev_reg <= i_converter_select_n;
      chan_prev_reg <= i_channel_select_n;
      aclk_prev_reg <= i_addr_clk;
      sclk_prev_reg <= i_shift_clk;
      rate_prev_reg <= i_rate_select_in;
    end
  end

  assign cs_rise = i_converter_select_n & ~cs_prev_reg;
  assign chan_fall = ~i_channel_select_n & chan_prev_reg;
  assign aclk_rise = i_addr_clk & ~aclk_prev_reg;
  assign sclk_fall = ~i_shift_clk & sclk_prev_reg & ~i_converter_select_n; // shifts ignored while deselected
  assign rate_rise = i_rate_select_in & ~rate_prev_reg;
  assign rate_edge = i_rate_select_in ^ rate_prev_reg;

  // ****************************************************************
  // conversion timebase
  // ****************************************************************
  localparam logic [7:0] DIV_50HZ = 8'(`CFG_DIV_50HZ);
  localparam logic [7:0] DIV_60HZ = 8'(`CFG_DIV_60HZ);
  logic [15:0] ext_timer_reg;
  logic [7:0] div_cnt_reg;
  logic ext_mode;
  logic conv_tick;

  // any toggle on the rate pin means an external clock; a steady level falls back
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ext_timer_reg <= 16'h0000;
    end else if (rate_edge) begin
      ext_timer_reg <= 16'(EXT_TIMEOUT);
    end else if (ext_timer_reg != 16'h0000) begin
      ext_timer_reg <= ext_timer_reg - 16'h0001;
    end
  end

  assign ext_mode = (ext_timer_reg != 16'h0000);

  // internal divider; the level picks the notch, high for 50 Hz and low for 60 Hz
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      div_cnt_reg <= 8'h00;
    end else if (div_cnt_reg == 8'h00) begin
      div_cnt_reg <= i_rate_select_in ? DIV_50HZ - 8'h01 : DIV_60HZ - 8'h01;
    end else begin
      div_cnt_reg <= div_cnt_reg - 8'h01;
    end
  end

  // external clock ticks on its own rising edges, so the null tracks its frequency
  assign conv_tick = ext_mode ? rate_rise : (div_cnt_reg == 8'h00);

  // ****************************************************************
  // registers written by software
  // ****************************************************************
  logic [31:0] conv_len_reg;
  logic [31:0] conv_len_eff;
  logic wr_pend_reg;
  logic [7:0] wr_addr_reg;

  // a zero length would never finish, so it runs as one tick
  assign conv_len_eff = (conv_len_reg == 32'h00000000) ? 32'h00000001 : conv_len_reg;

  // ****************************************************************
  // cycle sequencer
  // ****************************************************************
  mux_adc_pkg::cycle_state_t state_reg;
  logic [31:0] conv_cnt_reg;
  logic conv_done;
  logic [4:0] bit_cnt_reg;
  logic word_end;

  assign conv_done = (state_reg == mux_adc_pkg::ST_CONVERT) && conv_tick &&
                     (conv_cnt_reg >= conv_len_eff - 32'h00000001);
  assign word_end = (state_reg == mux_adc_pkg::ST_OUTPUT) && sclk_fall &&
                    (bit_cnt_reg == 5'(`CFG_WORD_BITS - 1));

  // offset and gain trims sit inside this tick budget, so the visible cycle is fixed
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      conv_cnt_reg <= 32'h00000000;
    end else if (state_reg != mux_adc_pkg::ST_CONVERT) begin
      conv_cnt_reg <= 32'h00000000;
    end else if (conv_tick) begin
      conv_cnt_reg <= conv_cnt_reg + 32'h00000001;
    end
  end

  // reset starts a conversion; the shift clock mode never changes the path taken
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_reg <= mux_adc_pkg::ST_CONVERT;
    end else begin
      case (state_reg)
        mux_adc_pkg::ST_CONVERT: begin
          if (conv_done) begin
            state_reg <= mux_adc_pkg::ST_SLEEP;
          end
        end
        mux_adc_pkg::ST_SLEEP: begin
          if (!i_converter_select_n) begin
            state_reg <= mux_adc_pkg::ST_OUTPUT;
          end
        end
        mux_adc_pkg::ST_OUTPUT: begin
          if (cs_rise || word_end) begin
            state_reg <= mux_adc_pkg::ST_CONVERT;
          end
        end
        default: begin
          state_reg <= mux_adc_pkg::ST_CONVERT;
        end
      endcase
    end
  end

  // ****************************************************************
  // result word and output shifter
  // ****************************************************************
  logic [21:0] clamped;
  logic sign_bit;
  logic range_bit;
  logic [23:0] word_next;
  logic [23:0] shift_reg;
  logic [23:0] result_reg;

  // beyond the extended range the code saturates at its ends
  always_comb begin
    clamped = i_filter_value;
    if (!i_filter_value[21] && (i_filter_value > `CFG_CODE_MAX_POS)) begin
      clamped = `CFG_CODE_MAX_POS;
    end else if (i_filter_value[21] && (i_filter_value < `CFG_CODE_MIN_NEG)) begin
      clamped = `CFG_CODE_MIN_NEG;
    end
  end

  // zero scale is value 0 and full scale fffff, so the low 20 bits are the code
  assign sign_bit = ~clamped[21];
  assign range_bit = clamped[21] | clamped[20];
  assign word_next = {1'b0, 1'b0, sign_bit, range_bit, clamped[19:0]};

  // loaded only at conversion end; shifts only on shift clock falls in data output
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      shift_reg <= 24'h000000;
      result_reg <= 24'h000000;
    end else if (conv_done) begin
      shift_reg <= word_next;
      result_reg <= word_next;
    end else if ((state_reg == mux_adc_pkg::ST_OUTPUT) && sclk_fall) begin
      shift_reg <= {shift_reg[22:0], 1'b1};
    end
  end

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      bit_cnt_reg <= 5'h00;
    end else if ((state_reg != mux_adc_pkg::ST_OUTPUT) || word_end || cs_rise) begin
      // cleared as the frame ends, so the next frame starts counting from zero
      bit_cnt_reg <= 5'h00;
    end else if (sclk_fall) begin
      bit_cnt_reg <= bit_cnt_reg + 5'h01;
    end
  end

  // status bit during conversion and sleep; word msb during output
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_sdo <= 1'b1;
      o_sdo_oe <= 1'b0;
      o_low_power <= 1'b0;
    end else begin
      o_sdo_oe <= ~i_converter_select_n;
      o_low_power <= (state_reg == mux_adc_pkg::ST_SLEEP) && i_converter_select_n;
      case (state_reg)
        mux_adc_pkg::ST_CONVERT: o_sdo <= 1'b1;
        mux_adc_pkg::ST_SLEEP: o_sdo <= 1'b0;
        mux_adc_pkg::ST_OUTPUT: o_sdo <= shift_reg[23];
        default: o_sdo <= 1'b1;
      endcase
    end
  end

  // ****************************************************************
  // channel address path
  // ****************************************************************
  logic [3:0] addr_shift_reg;
  logic [3:0] map_entry;
  logic result_valid_reg;

  // bits ride in on rising address clocks only while the select is high
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      addr_shift_reg <= 4'h0;
    end else if (i_channel_select_n && aclk_rise) begin
      addr_shift_reg <= {addr_shift_reg[2:0], i_addr_in};
    end
  end

  // entry is {enable, channel[2:0]}; the word decoding is left to integration
  assign map_entry = CHAN_MAP[{addr_shift_reg, 2'b00} +: 4];

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_channel_switch <= 8'h00;
      o_channel_enable <= 1'b0;
    end else if (chan_fall && (addr_shift_reg != 4'h0)) begin
      o_channel_enable <= map_entry[3];
      o_channel_switch <= map_entry[3] ? (8'h01 << map_entry[2:0]) : 8'h00;
    end
  end

  // the first result after reset converted a disabled channel and is flagged invalid
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      result_valid_reg <= 1'b0;
    end else if (conv_done) begin
      result_valid_reg <= o_channel_enable;
    end
  end

  // ****************************************************************
  // AHB-Lite slave: zero wait states, always OKAY
  // ****************************************************************
  logic addr_ok;
  logic [31:0] rd_value;

  assign addr_ok = i_hsel && i_htrans[1] && i_hready;

  always_comb begin
    rd_value = 32'h00000000;
    case (i_haddr[7:0])
      `CFG_OFF_CONV_LEN: rd_value = conv_len_reg;
      `CFG_OFF_STATUS: rd_value = {24'h000000, 2'b00, result_valid_reg, ext_mode, 1'b0, state_reg};
      `CFG_OFF_RESULT: rd_value = {8'h00, result_reg};
      `CFG_OFF_CHANNEL: rd_value = {23'h000000, o_channel_enable, o_channel_switch};
      default: rd_value = 32'h00000000;
    endcase
    if (i_haddr[31:8] != 24'h000000) begin
      rd_value = 32'h00000000;
    end
  end

  // read data is fetched in the address phase so hrdata comes from a flop
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_hrdata <= 32'h00000000;
      o_hreadyout <= 1'b1;
      o_hresp <= 1'b0;
    end else begin
      o_hreadyout <= 1'b1;
      o_hresp <= 1'b0;
      if (addr_ok && !i_hwrite) begin
        o_hrdata <= rd_value;
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
    end else begin
      wr_pend_reg <= addr_ok && i_hwrite && (i_haddr[31:8] == 24'h000000);
      wr_addr_reg <= i_haddr[7:0];
    end
  end

  // only the conversion length is writable; other offsets drop the write
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      conv_len_reg <= `CFG_RST_CONV_LEN;
    end else if (wr_pend_reg && (wr_addr_reg == `CFG_OFF_CONV_LEN)) begin
      conv_len_reg <= i_hwdata;
    end
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  sdo_float_a: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    i_converter_select_n |=> !o_sdo_oe)
    else $error("serial output driven while deselected");

  auto_sleep_a: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    conv_done |=> (state_reg == mux_adc_pkg::ST_SLEEP))
    else $error("no sleep after conversion");

  sleep_hold_a: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    (state_reg == mux_adc_pkg::ST_SLEEP) ##1 (state_reg == mux_adc_pkg::ST_SLEEP) |-> $stable(shift_reg))
    else $error("result changed during sleep");

  abort_output_a: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    (state_reg == mux_adc_pkg::ST_OUTPUT) && cs_rise |=> (state_reg == mux_adc_pkg::ST_CONVERT))
    else $error("select rise did not abort output");

  busy_status_a: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    (state_reg == mux_adc_pkg::ST_CONVERT) && !i_converter_select_n |=> o_sdo && o_sdo_oe)
    else $error("busy status not shown");

  output_start_a: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    (state_reg == mux_adc_pkg::ST_SLEEP) && !i_converter_select_n |=> (state_reg == mux_adc_pkg::ST_OUTPUT))
    else $error("data output did not start");

  fall_shift_a: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    (state_reg == mux_adc_pkg::ST_OUTPUT) && !sclk_fall |=> $stable(shift_reg))
    else $error("shift without a falling shift clock");

  word_done_a: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    word_end |=> (state_reg == mux_adc_pkg::ST_CONVERT) && (bit_cnt_reg == 5'h00))
    else $error("output not ended after 24 bits");

  ones_fill_a: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    (state_reg == mux_adc_pkg::ST_OUTPUT) && sclk_fall && !conv_done |=> shift_reg[0])
    else $error("fill bit not high");

  zero_keep_a: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    chan_fall && (addr_shift_reg == 4'h0) |=> $stable(o_channel_switch) && $stable(o_channel_enable))
    else $error("zero word changed channel");

  addr_capture_a: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    i_channel_select_n && aclk_rise |=> addr_shift_reg == {$past(addr_shift_reg[2:0]), $past(i_addr_in)})
    else $error("address bit not captured");

endmodule
`default_nettype wire

// [mux_adc_host.sv]
/*
 * host model for the converter cycle controller: one select and one link clock, four-wire use.
 * assumes the caller enters every task just after a rising edge of i_mclk.
 */
`timescale 1ns/1ns
`default_nettype none
// ****************************************************************
// host side of the serial link
// ****************************************************************
module mux_adc_host (
  input wire logic i_mclk,
  input wire logic i_sdo,
  output logic o_select_n,
  output logic o_link_clk,
  output logic o_addr_in
);
  // idle: deselected, clock low; outside frames the clock runs only to load the address
  initial begin
    o_select_n = 1'b1;
    o_link_clk = 1'b0;
    o_addr_in = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge i_mclk);
  endtask
  // one select line feeds both the mux and the converter select
  task automatic select(input logic v);
    o_select_n <= v;
  endtask
  // five mclk low then four high, slow enough for the two-stage output path
  task automatic pulse(input logic d, output logic q);
    o_addr_in <= d;
    tick(4);
    @(negedge i_mclk) q = i_sdo;
    @(posedge i_mclk) o_link_clk <= 1'b1;
    tick(4);
    o_link_clk <= 1'b0;
  endtask
  // address loaded msb first while deselected; the line is then flipped as a released wire
  task automatic load_channel(input logic [7:0] b);
    logic q;
    for (int i = 7; i >= 0; i--) pulse(b[i], q);
    tick(1);
    o_addr_in <= ~b[0];
  endtask
  task automatic shift(input int n, output logic [31:0] w);
    logic q;
    w = 32'h0;
    for (int i = 0; i < n; i++) begin
      pulse(i[0], q);
      w = {w[30:0], q};
    end
  endtask
endmodule
`default_nettype wire

// [mux_adc_pkg.sv]
/*
 * types shared by the converter cycle controller.
 * assumes nothing beyond a SystemVerilog compiler.
 */
package mux_adc_pkg;

  // ****************************************************************
  // operating cycle states, one-hot
  // ****************************************************************
  typedef enum logic [2:0] {
    ST_CONVERT = 3'b001,
    ST_SLEEP = 3'b010,
    ST_OUTPUT = 3'b100
  } cycle_state_t;

endpackage

// [mux_adc_serial_cycle_control_bench.sv]
/*
 * self-checking bench for the converter cycle controller: bus, host link and filter stimulus.
 * assumes the host model in mux_adc_host.sv; conversions shortened through the length register.
 */
`timescale 1ns/1ns
`default_nettype none
// ****************************************************************
// bench top
// ****************************************************************
module mux_adc_serial_cycle_control_bench;
  logic mclk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, rate = 1'b1, ext_on = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, st;
  logic [21:0] filt = 22'h0fffff;
  wire logic [31:0] hrdata;
  wire logic hready, hresp, sdo, sdo_oe, ch_en, lowp, cs_n, sck, din;
  wire logic [7:0] ch_sw;
  int miscompares = 0, compares = 0, cycles = 0;

  always #25 mclk = ~mclk;
  // hang guard, far above the few thousand cycles the tests need
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      miscompares++;
      complete_run();
    end
  end
  // external conversion clock: one tick every two mclk
  always @(posedge mclk) if (ext_on) rate <= ~rate;

  mux_adc_ctrl #(.EXT_TIMEOUT(64)) dut (.i_mclk(mclk), .i_reset_n(rst_n), .i_hsel(hsel),
    .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata),
    .i_hready(hready), .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp),
    .i_converter_select_n(cs_n), .i_channel_select_n(cs_n), .i_addr_clk(sck), .i_addr_in(din),
    .i_shift_clk(sck), .i_rate_select_in(rate), .i_filter_value(filt), .o_sdo(sdo),
    .o_sdo_oe(sdo_oe), .o_channel_switch(ch_sw), .o_channel_enable(ch_en), .o_low_power(lowp));
  mux_adc_host host (.i_mclk(mclk), .i_sdo(sdo), .o_select_n(cs_n), .o_link_clk(sck), .o_addr_in(din));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // single word transfer; waits on hready rather than assuming a latency
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    hsize <= 3'h2;
    do @(posedge mclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge mclk); while (hready !== 1'b1);
    q = hrdata;
  endtask
  task automatic wait_sleep(output int n);
    for (n = 0; n < 2000; n++) begin
      bus(1'b0, 32'h4, 32'h0, st);
      if (st[2:0] === 3'h2) break;
    end
    // a sleep that never comes is a failure, not a silent exit
    chk(n < 2000, 32'h1);
  endtask
  task automatic fetch(input logic [7:0] cw, input logic [31:0] ch, input int nb, output logic [31:0] w);
    host.load_channel(cw);
    host.select(1'b0);
    host.tick(3);
    chk({23'h0, ch_en, ch_sw}, ch);
    host.shift(nb, w);
    host.select(1'b1);
  endtask

  task automatic t_start();
    logic [31:0] q;
    int n;
    bus(1'b0, 32'h0, 32'h0, q);
    chk(q, 32'h501e);
    bus(1'b0, 32'h40, 32'h0, q);
    chk(q, 32'h0);
    bus(1'b1, 32'h0, 32'h4, q);
    bus(1'b0, 32'h0, 32'h0, q);
    chk(q, 32'h4);
    wait_sleep(n);
    chk(st[5], 32'h0);
    chk({lowp, sdo_oe}, 32'h2);
    $display("test start done");
  endtask
  task automatic t_output();
    logic [31:0] w;
    fetch(8'h38, 32'h101, 32, w);
    chk(w, 32'h2fffffff);
    host.tick(2);
    chk(sdo_oe, 32'h0);
    $display("test output done");
  endtask
  task automatic t_levels();
    logic [21:0] fv[3] = '{22'h000000, 22'h100000, 22'h080000};
    logic [23:0] ev[3] = '{24'h200000, 24'h300000, 24'h280000};
    logic [7:0] cw[3] = '{8'hf0, 8'h0f, 8'h09};
    logic [31:0] ch[3] = '{32'h101, 32'h180, 32'h102};
    logic [31:0] w;
    int n;
    for (int i = 0; i < 3; i++) begin
      filt <= fv[i];
      wait_sleep(n);
      host.tick(50);
      chk({st[5], lowp}, 32'h3);
      fetch(cw[i], ch[i], 24, w);
      chk(w, {8'h0, ev[i]});
      bus(1'b0, 32'h8, 32'h0, w);
      chk(w, {8'h0, ev[i]});
    end
    $display("test levels done");
  endtask
  task automatic t_abort();
    logic [31:0] w;
    int n;
    wait_sleep(n);
    host.select(1'b0);
    host.shift(4, w);
    chk(w, 32'h2);
    host.select(1'b1);
    host.tick(3);
    bus(1'b0, 32'h4, 32'h0, st);
    chk(st[2:0], 32'h1);
    host.select(1'b0);
    host.tick(3);
    chk({sdo_oe, sdo}, 32'h3);
    host.select(1'b1);
    $display("test abort done");
  endtask
  // a short output frame aborted restarts the conversion at the new rate
  task automatic restart();
    host.select(1'b0);
    host.tick(3);
    host.select(1'b1);
  endtask
  task automatic t_rate();
    int n, n50, n60;
    rate <= 1'b0;
    wait_sleep(n);
    restart();
    wait_sleep(n60);
    rate <= 1'b1;
    restart();
    wait_sleep(n50);
    chk(n50 > n60, 32'h1);
    ext_on <= 1'b1;
    restart();
    wait_sleep(n);
    chk({st[4], n < n60}, 32'h3);
    ext_on <= 1'b0;
    host.tick(1);
    rate <= 1'b1;
    host.tick(100);
    bus(1'b0, 32'h4, 32'h0, st);
    chk(st[4], 32'h0);
    $display("test rate done");
  endtask

  task automatic complete_run();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // reset for four cycles, outputs checked while it is held
  initial begin
    repeat (2) @(posedge mclk);
    chk({27'h0, hready, sdo_oe, ch_en, lowp, hresp}, 32'h10);
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    t_start();
    t_output();
    t_levels();
    t_abort();
    t_rate();
    complete_run();
  end
endmodule
`default_nettype wire
